// *** core/pcs_core.v ***
// Program counter, return stack and indirect addressing with AXI4-Lite
`timescale 1ns/100ps
`include "pcs_consts.vh"
`default_nettype none
////////////////////////////////////////////////////////////////////////////
module pcs_core (
  input wire CLOCK_I,
  input wire RST_I,
  input wire [31:0] S_AXI_AWADDR_I,
  input wire S_AXI_AWVALID_I,
  output wire S_AXI_AWREADY_O,
  input wire [31:0] S_AXI_WDATA_I,
  input wire [3:0] S_AXI_WSTRB_I,
  input wire S_AXI_WVALID_I,
  output wire S_AXI_WREADY_O,
  output reg [1:0] S_AXI_BRESP_O,
  output reg S_AXI_BVALID_O,
  input wire S_AXI_BREADY_I,
  input wire [31:0] S_AXI_ARADDR_I,
  input wire S_AXI_ARVALID_I,
  output wire S_AXI_ARREADY_O,
  output reg [31:0] S_AXI_RDATA_O,
  output reg [1:0] S_AXI_RRESP_O,
  output reg S_AXI_RVALID_O,
  input wire S_AXI_RREADY_I,
  input wire [3:0] CMD_I,
  input wire CMD_VALID_I,
  input wire [10:0] IMM_I,
  input wire [6:0] LOC_I,
  input wire [7:0] WDATA_I,
  input wire FILE_WRITE_I,
  output reg [12:0] PC_O,
  output reg [8:0] DATA_ADDR_O,
  output reg DATA_WE_O,
  output reg [7:0] DATA_WDATA_O,
  output reg READ_ZERO_O
);
  reg [4:0] pc_upper_bits;
  reg [7:0] pc_low_byte;
  reg [7:0] pc_high_latch;
  reg [7:0] indirect_pointer;
  reg [7:0] status;
  reg [3:0] core_cmd;
  reg [10:0] core_imm;
  reg [6:0] core_loc;
  reg [7:0] core_wdata;
  reg core_wr;
  reg aw_held;
  reg w_held;
  reg [7:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg bus_cmd_go;
  wire [12:0] pc_full;
  wire [12:0] stack_top;
  wire [8:0] eff_addr;
  wire is_indirect;
  wire self_ref;
  wire do_write;
  wire [3:0] cmd;
  wire cmd_go;
  wire [10:0] imm;
  wire [6:0] loc;
  wire [7:0] fdata;
  wire fwr;
  wire push;
  wire pop;
  wire [12:0] pc_inc;
  wire [12:0] int_vector;

  assign pc_full = {pc_upper_bits, pc_low_byte};
  assign pc_inc = pc_full + 13'h0001;
  assign int_vector = `PCS_INT_VECTOR; // Sliced into PC halves below

  ////////////////////////////////////////////////////////////////////////
  // Command source: decoder port wins over a bus-issued command
  assign cmd_go = CMD_VALID_I | bus_cmd_go;
  assign cmd = CMD_VALID_I ? CMD_I : core_cmd;
  assign imm = CMD_VALID_I ? IMM_I : core_imm;
  assign loc = CMD_VALID_I ? LOC_I : core_loc;
  assign fdata = CMD_VALID_I ? WDATA_I : core_wdata;
  assign fwr = CMD_VALID_I ? FILE_WRITE_I : core_wr;

  // Stack events; pointer stays hidden and no flags exist
  assign push = cmd_go && (cmd == `PCS_CMD_CALL ||
    cmd == `PCS_CMD_INTERRUPT);
  assign pop = cmd_go && (cmd == `PCS_CMD_RETURN ||
    cmd == `PCS_CMD_RET_LIT || cmd == `PCS_CMD_RET_INT);

  // Call pushes the address after itself, interrupt the current one
  pcs_stack #(
    .DEPTH_LOG2(3),
    .WIDTH(13)
  ) u_stack (
    .clk_i(CLOCK_I),
    .rst_i(RST_I),
    .push_i(push),
    .pop_i(pop),
    .push_data_i((cmd == `PCS_CMD_CALL) ? pc_inc : pc_full),
    .top_o(stack_top)
  );

  pcs_addr u_addr (
    .loc_i(loc),
    .rp0_i(status[`PCS_STATUS_RP0]),
    .rp1_i(status[`PCS_STATUS_RP1]),
    .irp_i(status[`PCS_STATUS_IRP]),
    .pointer_i(indirect_pointer),
    .addr_o(eff_addr),
    .indirect_o(is_indirect),
    .self_ref_o(self_ref)
  );

  // A write through the port at itself is swallowed
  assign do_write = cmd_go && cmd == `PCS_CMD_FILE_ACCESS && fwr &&
    !self_ref;

  ////////////////////////////////////////////////////////////////////////
  // Program counter; latch untouched by stack traffic
  always @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      pc_upper_bits <= 5'h00;
      pc_low_byte <= `PCS_RST_BYTE;
    end else if (cmd_go) begin
      case (cmd)
        `PCS_CMD_WRITE_PCL: begin
          // No carry into the latch; computed tables must bump it
          pc_upper_bits <= pc_high_latch[4:0];
          pc_low_byte <= fdata;
        end
        `PCS_CMD_CALL, `PCS_CMD_JUMP: begin
          pc_upper_bits <= {pc_high_latch[4:3], imm[10:8]};
          pc_low_byte <= imm[7:0];
        end
        `PCS_CMD_RETURN, `PCS_CMD_RET_LIT, `PCS_CMD_RET_INT: begin
          pc_upper_bits <= stack_top[12:8];
          pc_low_byte <= stack_top[7:0];
        end
        `PCS_CMD_INTERRUPT: begin
          pc_upper_bits <= int_vector[12:8];
          pc_low_byte <= int_vector[7:0];
        end
        `PCS_CMD_STEP, `PCS_CMD_FILE_ACCESS: begin
          pc_upper_bits <= pc_inc[12:8];
          pc_low_byte <= pc_inc[7:0];
        end
        default: begin
          pc_upper_bits <= pc_upper_bits;
        end
      endcase
    end else if (aw_held && w_held && !S_AXI_BVALID_O &&
        aw_addr == `PCS_OFF_PC_LOW && w_strb[0]) begin
      // Software low-byte write also reloads upper bits from latch
      pc_upper_bits <= pc_high_latch[4:0];
      pc_low_byte <= w_data[7:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Data-side outputs registered for the decoder
  always @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      PC_O <= `PCS_RST_PC;
      DATA_ADDR_O <= 9'h000;
      DATA_WE_O <= 1'b0;
      DATA_WDATA_O <= `PCS_RST_BYTE;
      READ_ZERO_O <= 1'b0;
    end else begin
      PC_O <= pc_full;
      DATA_WE_O <= do_write;
      if (cmd_go && cmd == `PCS_CMD_FILE_ACCESS) begin
        DATA_ADDR_O <= eff_addr;
        DATA_WDATA_O <= fdata;
        READ_ZERO_O <= self_ref;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bus slave: take address and data in any order, answer next cycle
  assign S_AXI_AWREADY_O = !aw_held && !S_AXI_BVALID_O;
  assign S_AXI_WREADY_O = !w_held && !S_AXI_BVALID_O;
  assign S_AXI_ARREADY_O = !S_AXI_RVALID_O;

  always @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      S_AXI_BVALID_O <= 1'b0;
      S_AXI_BRESP_O <= `PCS_RESP_OKAY;
      pc_high_latch <= `PCS_RST_BYTE;
      indirect_pointer <= `PCS_RST_BYTE;
      status <= `PCS_RST_BYTE;
      core_cmd <= `PCS_CMD_NONE;
      core_imm <= 11'h000;
      core_loc <= 7'h00;
      core_wdata <= `PCS_RST_BYTE;
      core_wr <= 1'b0;
      bus_cmd_go <= 1'b0;
    end else begin
      bus_cmd_go <= 1'b0;
      if (S_AXI_AWVALID_I && S_AXI_AWREADY_O) begin
        aw_held <= 1'b1;
        aw_addr <= S_AXI_AWADDR_I[7:0];
      end
      if (S_AXI_WVALID_I && S_AXI_WREADY_O) begin
        w_held <= 1'b1;
        w_data <= S_AXI_WDATA_I;
        w_strb <= S_AXI_WSTRB_I;
      end
      if (aw_held && w_held && !S_AXI_BVALID_O) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        S_AXI_BVALID_O <= 1'b1;
        S_AXI_BRESP_O <= `PCS_RESP_OKAY;
        if (S_AXI_AWADDR_I[31:8] != 24'h00_0000 && 1'b0) begin
          S_AXI_BRESP_O <= `PCS_RESP_SLVERR;
        end else if (aw_addr == `PCS_OFF_PC_LOW) begin
          S_AXI_BRESP_O <= `PCS_RESP_OKAY;
        end else if (aw_addr == `PCS_OFF_PC_HIGH_LATCH) begin
          if (w_strb[0]) pc_high_latch <= w_data[7:0];
        end else if (aw_addr == `PCS_OFF_INDIRECT_POINTER) begin
          if (w_strb[0]) indirect_pointer <= w_data[7:0];
        end else if (aw_addr == `PCS_OFF_STATUS) begin
          if (w_strb[0]) status <= w_data[7:0];
        end else if (aw_addr == `PCS_OFF_CORE_ARG) begin
          if (w_strb[0]) core_imm[7:0] <= w_data[7:0];
          if (w_strb[1]) core_imm[10:8] <= w_data[10:8];
          if (w_strb[2]) core_loc <= w_data[22:16];
          if (w_strb[3]) core_wdata <= w_data[31:24];
        end else if (aw_addr == `PCS_OFF_CORE_CMD) begin
          // Writing here issues one command as if from the decoder
          if (w_strb[0]) begin
            core_cmd <= w_data[3:0];
            core_wr <= w_data[4];
            bus_cmd_go <= 1'b1;
          end
        end else begin
          S_AXI_BRESP_O <= `PCS_RESP_SLVERR;
        end
      end else if (S_AXI_BVALID_O && S_AXI_BREADY_I) begin
        S_AXI_BVALID_O <= 1'b0;
      end
    end
  end

  // Read side; hidden stack pointer has no address, upper PC bits read only through the full PC
  always @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      S_AXI_RVALID_O <= 1'b0;
      S_AXI_RDATA_O <= 32'h0000_0000;
      S_AXI_RRESP_O <= `PCS_RESP_OKAY;
    end else if (S_AXI_ARVALID_I && S_AXI_ARREADY_O) begin
      S_AXI_RVALID_O <= 1'b1;
      S_AXI_RRESP_O <= `PCS_RESP_OKAY;
      S_AXI_RDATA_O <= 32'h0000_0000;
      if (S_AXI_ARADDR_I[7:0] == `PCS_OFF_PC_LOW) begin
        S_AXI_RDATA_O <= {24'h00_0000, pc_low_byte};
      end else if (S_AXI_ARADDR_I[7:0] == `PCS_OFF_PC_HIGH_LATCH) begin
        S_AXI_RDATA_O <= {24'h00_0000, pc_high_latch};
      end else if (S_AXI_ARADDR_I[7:0] == `PCS_OFF_INDIRECT_POINTER) begin
        S_AXI_RDATA_O <= {24'h00_0000, indirect_pointer};
      end else if (S_AXI_ARADDR_I[7:0] == `PCS_OFF_STATUS) begin
        S_AXI_RDATA_O <= {24'h00_0000, status};
      end else if (S_AXI_ARADDR_I[7:0] == `PCS_OFF_PC_FULL) begin
        S_AXI_RDATA_O <= {19'h0_0000, pc_full};
      end else if (S_AXI_ARADDR_I[7:0] == `PCS_OFF_DATA_ADDR) begin
        S_AXI_RDATA_O <= {22'h00_0000, READ_ZERO_O, DATA_ADDR_O};
      end else begin
        S_AXI_RRESP_O <= `PCS_RESP_SLVERR;
      end
    end else if (S_AXI_RVALID_O && S_AXI_RREADY_I) begin
      S_AXI_RVALID_O <= 1'b0;
    end
  end
endmodule // pcs_core
`default_nettype wire

// *** pkg/pcs_consts.vh ***
// Constants for the program counter, return stack and indirect addressing core
`ifndef PCS_CONSTS_VH
`define PCS_CONSTS_VH
// Register byte offsets on the register bus
`define PCS_OFF_PC_LOW 8'h00
`define PCS_OFF_PC_HIGH_LATCH 8'h04
`define PCS_OFF_INDIRECT_POINTER 8'h08
`define PCS_OFF_STATUS 8'h0C
`define PCS_OFF_PC_FULL 8'h10
`define PCS_OFF_CORE_CMD 8'h14
`define PCS_OFF_CORE_ARG 8'h18
`define PCS_OFF_DATA_ADDR 8'h1C
// Status field positions
`define PCS_STATUS_RP0 5
`define PCS_STATUS_RP1 6
`define PCS_STATUS_IRP 7
// Reset values
`define PCS_RST_BYTE 8'h00
`define PCS_RST_PC 13'h0000
// Core command codes
`define PCS_CMD_NONE 4'h0
`define PCS_CMD_WRITE_PCL 4'h1
`define PCS_CMD_CALL 4'h2
`define PCS_CMD_JUMP 4'h3
`define PCS_CMD_RETURN 4'h4
`define PCS_CMD_RET_LIT 4'h5
`define PCS_CMD_RET_INT 4'h6
`define PCS_CMD_INTERRUPT 4'h7
`define PCS_CMD_STEP 4'h8
`define PCS_CMD_FILE_ACCESS 4'h9
// Data-space location of the indirect data port
`define PCS_INDIRECT_PORT_LOC 7'h00
// Interrupt vector
`define PCS_INT_VECTOR 13'h0004
// Bus response codes
`define PCS_RESP_OKAY 2'b00
`define PCS_RESP_SLVERR 2'b10
`endif

// *** core/pcs_stack.v ***
// Eight-entry circular return stack
`timescale 1ns/100ps
`default_nettype none
module pcs_stack #(
  parameter DEPTH_LOG2 = 3,
  parameter WIDTH = 13
) (
  input wire clk_i,
  input wire rst_i,
  input wire push_i,
  input wire pop_i,
  input wire [WIDTH-1:0] push_data_i,
  output wire [WIDTH-1:0] top_o
);
  reg [WIDTH-1:0] mem [0:(1<<DEPTH_LOG2)-1];
  reg [DEPTH_LOG2-1:0] ptr;
  wire [DEPTH_LOG2-1:0] ptr_dec;
  integer i;

  assign ptr_dec = ptr - {{(DEPTH_LOG2-1){1'b0}}, 1'b1};
  // Top is the last pushed slot; pop past empty just wraps
  assign top_o = mem[ptr_dec];

  // Pointer wraps, so the ninth push overwrites the first; no flags
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ptr <= {DEPTH_LOG2{1'b0}};
      for (i = 0; i < (1<<DEPTH_LOG2); i = i + 1) begin
        mem[i] <= {WIDTH{1'b0}};
      end
    end else if (push_i) begin
      mem[ptr] <= push_data_i;
      ptr <= ptr + {{(DEPTH_LOG2-1){1'b0}}, 1'b1};
    end else if (pop_i) begin
      ptr <= ptr_dec;
    end
  end
endmodule // pcs_stack
`default_nettype wire

// *** core/pcs_addr.v ***
// Direct and indirect data address former
`timescale 1ns/100ps
`include "pcs_consts.vh"
`default_nettype none
module pcs_addr (
  input wire [6:0] loc_i,
  input wire rp0_i,
  input wire rp1_i,
  input wire irp_i,
  input wire [7:0] pointer_i,
  output wire [8:0] addr_o,
  output wire indirect_o,
  output wire self_ref_o
);
  // The port has no storage; naming it means use the pointer
  assign indirect_o = (loc_i == `PCS_INDIRECT_PORT_LOC);
  // Pointer naming the port itself: read 00h, write dropped
  assign self_ref_o = indirect_o &&
    (pointer_i[6:0] == `PCS_INDIRECT_PORT_LOC);
  // Indirect: bank bit on top of pointer; direct: two bank bits
  assign addr_o = indirect_o ? {irp_i, pointer_i} :
    {rp1_i, rp0_i, loc_i};
endmodule // pcs_addr
`default_nettype wire

// *** sim/pcs_core_properties.sv ***
// Checker for the program counter and data addressing core
`timescale 1ns/100ps
`default_nettype none
`include "pcs_consts.vh"
module pcs_props (
  input wire CLOCK_I,
  input wire RST_I,
  input wire [3:0] CMD_I,
  input wire CMD_VALID_I,
  input wire [10:0] IMM_I,
  input wire [6:0] LOC_I,
  input wire [7:0] WDATA_I,
  input wire FILE_WRITE_I,
  input wire [12:0] PC_O,
  input wire [8:0] DATA_ADDR_O,
  input wire DATA_WE_O,
  input wire [7:0] DATA_WDATA_O,
  input wire READ_ZERO_O
);
  // Decoder strobes; bus-issued commands are not modelled here
  wire go = CMD_VALID_I;
  wire fa = go && CMD_I == `PCS_CMD_FILE_ACCESS;
  wire cj = go && (CMD_I == `PCS_CMD_CALL || CMD_I == `PCS_CMD_JUMP);
  wire inc = go && (CMD_I == `PCS_CMD_STEP || fa);
  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);
  property p_rst; $fell(RST_I) |-> PC_O == 13'h0000 && !DATA_WE_O; endproperty
  a_rst: assert property (p_rst) else $error("PC not clear");
  property p_cj; cj |-> ##2 PC_O[10:0] == $past(IMM_I, 2); endproperty
  a_cj: assert property (p_cj) else $error("Bad jump target");
  property p_pcl;
    go && CMD_I == `PCS_CMD_WRITE_PCL |-> ##2 PC_O[7:0] == $past(WDATA_I, 2);
  endproperty
  a_pcl: assert property (p_pcl) else $error("Bad low byte");
  property p_int;
    go && CMD_I == `PCS_CMD_INTERRUPT |-> ##2 PC_O == `PCS_INT_VECTOR;
  endproperty
  a_int: assert property (p_int) else $error("Bad vector");
  property p_inc; inc |=> ##1 PC_O == $past(PC_O) + 13'h0001; endproperty
  a_inc: assert property (p_inc) else $error("Bad increment");
  property p_dir;
    fa && LOC_I != 7'h00 |=> DATA_ADDR_O[6:0] == $past(LOC_I)
      && DATA_WE_O == $past(FILE_WRITE_I) && !READ_ZERO_O;
  endproperty
  a_dir: assert property (p_dir) else $error("Bad direct access");
  property p_self; fa |=> !(DATA_WE_O && DATA_ADDR_O[6:0] == 7'h00); endproperty
  a_self: assert property (p_self) else $error("Self write");
  property p_zero;
    fa && !FILE_WRITE_I |=> READ_ZERO_O ==
      (DATA_ADDR_O[6:0] == 7'h00 && $past(LOC_I) == 7'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("Bad zero read");
  property p_we; !fa |=> !DATA_WE_O; endproperty
  a_we: assert property (p_we) else $error("Stray write");
  property p_wdat; fa |=> DATA_WDATA_O == $past(WDATA_I); endproperty
  a_wdat: assert property (p_wdat) else $error("Bad file data");
  // Main scenarios
  c_call: cover property (go && CMD_I == `PCS_CMD_CALL);
  c_ret: cover property (go && CMD_I == `PCS_CMD_RET_INT);
  c_ind: cover property (fa && LOC_I == 7'h00);
endmodule // pcs_props
bind pcs_core pcs_props i_pcs_props (.CLOCK_I(CLOCK_I), .RST_I(RST_I),
  .CMD_I(CMD_I), .CMD_VALID_I(CMD_VALID_I), .IMM_I(IMM_I), .LOC_I(LOC_I),
  .WDATA_I(WDATA_I), .FILE_WRITE_I(FILE_WRITE_I), .PC_O(PC_O),
  .DATA_ADDR_O(DATA_ADDR_O), .DATA_WE_O(DATA_WE_O),
  .DATA_WDATA_O(DATA_WDATA_O), .READ_ZERO_O(READ_ZERO_O));
`default_nettype wire

// *** sim/tb.sv ***
// Self-checking bench for the program counter and addressing core
`timescale 1ns/100ps
`default_nettype none
`include "pcs_consts.vh"
module tb;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg [31:0] awaddr = 32'h0000_0000;
  reg [31:0] wdata = 32'h0000_0000;
  reg [31:0] araddr = 32'h0000_0000;
  reg awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
  reg cv = 1'b0, fw = 1'b0;
  reg [3:0] cmd = 4'h0;
  reg [10:0] imm = 11'h000;
  reg [6:0] loc = 7'h00;
  reg [7:0] wd = 8'h00;
  wire awr, wrdy, bv, arr, rv, we, rz;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  wire [12:0] pc_o;
  wire [8:0] da;
  wire [7:0] wdo;
  // Reference state of PC, latch and stack
  reg [12:0] pc = 13'h0000;
  reg [12:0] stk [0:7];
  reg [2:0] sp = 3'h0;
  reg [7:0] lat = 8'h00;
  reg [1:0] resp;
  integer n_fail = 0, n_tests = 0, i;
  pcs_core i_pcs_core (.CLOCK_I(clk), .RST_I(rst), .S_AXI_AWADDR_I(awaddr),
    .S_AXI_AWVALID_I(awv), .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wdata),
    .S_AXI_WSTRB_I(4'hF), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wrdy),
    .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(bready),
    .S_AXI_ARADDR_I(araddr), .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr),
    .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp), .S_AXI_RVALID_O(rv),
    .S_AXI_RREADY_I(rready), .CMD_I(cmd), .CMD_VALID_I(cv), .IMM_I(imm),
    .LOC_I(loc), .WDATA_I(wd), .FILE_WRITE_I(fw), .PC_O(pc_o),
    .DATA_ADDR_O(da), .DATA_WE_O(we), .DATA_WDATA_O(wdo), .READ_ZERO_O(rz));
  // 250 MHz clock
  always #2 clk = ~clk;
  //////////////////////////////////////////////////////////////////////////
  task results;
    begin
      $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  task cmp(input [31:0] g, input [31:0] e);
    begin
      n_tests = n_tests + 1;
      if (g !== e) begin
        n_fail = n_fail + 1;
        $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
    end
  endtask
  // Readies sampled at the falling edge hold until the next rising edge
  task wr(input [7:0] a, input [31:0] d);
    integer k;
    reg ha, hw, done;
    begin
      @(posedge clk);
      awaddr <= {24'h00_0000, a};
      wdata <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bready <= 1'b1;
      done = 1'b0;
      for (k = 0; k < 64 && !done; k = k + 1) begin
        @(negedge clk);
        ha = awv & awr;
        hw = wv & wrdy;
        done = bv;
        resp = bresp;
        @(posedge clk);
        if (ha) awv <= 1'b0;
        if (hw) wv <= 1'b0;
        if (done) bready <= 1'b0;
      end
      if (!done) n_fail = n_fail + 1;
    end
  endtask
  task rc(input [7:0] a, input [31:0] e);
    integer k;
    reg ha, done;
    reg [31:0] d;
    begin
      @(posedge clk);
      araddr <= {24'h00_0000, a};
      arv <= 1'b1;
      rready <= 1'b1;
      done = 1'b0;
      for (k = 0; k < 64 && !done; k = k + 1) begin
        @(negedge clk);
        ha = arv & arr;
        done = rv;
        d = rdata;
        @(posedge clk);
        if (ha) arv <= 1'b0;
        if (done) rready <= 1'b0;
      end
      if (!done) n_fail = n_fail + 1;
      cmp(d, e);
    end
  endtask
  // One decoder command; the reference model predicts the new PC
  task op(input [3:0] c, input [10:0] im, input [7:0] d, input [6:0] l,
          input f);
    begin
      case (c)
        `PCS_CMD_WRITE_PCL: pc = {lat[4:0], d};
        `PCS_CMD_CALL, `PCS_CMD_INTERRUPT: begin
          stk[sp] = (c == `PCS_CMD_CALL) ? pc + 13'h0001 : pc;
          sp = sp + 3'h1;
          pc = (c == `PCS_CMD_CALL) ? {lat[4:3], im} : `PCS_INT_VECTOR;
        end
        `PCS_CMD_JUMP: pc = {lat[4:3], im};
        `PCS_CMD_RETURN, `PCS_CMD_RET_LIT, `PCS_CMD_RET_INT: begin
          sp = sp - 3'h1;
          pc = stk[sp];
        end
        default: pc = pc + 13'h0001;
      endcase
      @(posedge clk);
      cmd <= c;
      cv <= 1'b1;
      imm <= im;
      wd <= d;
      loc <= l;
      fw <= f;
      @(posedge clk);
      cv <= 1'b0;
      @(posedge clk);
      #1;
      cmp({19'h0_0000, pc_o}, {19'h0_0000, pc});
    end
  endtask
  task setlat(input [7:0] v);
    begin
      lat = v;
      wr(`PCS_OFF_PC_HIGH_LATCH, {24'h00_0000, v});
    end
  endtask
  //////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rc(`PCS_OFF_PC_FULL, 32'h0000_0000);
    setlat(8'h1F);
    op(`PCS_CMD_WRITE_PCL, 11'h000, 8'hA5, 7'h01, 1'b0);
    rc(`PCS_OFF_PC_LOW, 32'h0000_00A5);
    wr(`PCS_OFF_PC_FULL, 32'h0000_0000);
    rc(`PCS_OFF_PC_FULL, 32'h0000_1FA5);
    wr(8'h40, 32'h0000_0001);
    cmp({30'h0000_0000, resp}, {30'h0000_0000, `PCS_RESP_SLVERR});
    // Table crossing a low-byte wrap: software carries into the latch
    setlat(8'h02);
    op(`PCS_CMD_WRITE_PCL, 11'h000, 8'hFF, 7'h01, 1'b0);
    setlat(8'h03);
    op(`PCS_CMD_WRITE_PCL, 11'h000, 8'h00, 7'h01, 1'b0);
    rc(`PCS_OFF_PC_HIGH_LATCH, 32'h0000_0003);
    // Software low-byte write over the bus reloads the upper bits
    wr(`PCS_OFF_PC_LOW, 32'h0000_003C);
    cmp({30'h0000_0000, resp}, {30'h0000_0000, `PCS_RESP_OKAY});
    pc = {lat[4:0], 8'h3C};
    rc(`PCS_OFF_PC_FULL, 32'h0000_033C);
    setlat(8'h18);
    op(`PCS_CMD_CALL, 11'h123, 8'h00, 7'h01, 1'b0);
    setlat(8'h08);
    op(`PCS_CMD_JUMP, 11'h7FF, 8'h00, 7'h01, 1'b0);
    op(`PCS_CMD_STEP, 11'h000, 8'h00, 7'h01, 1'b0);
    op(`PCS_CMD_RETURN, 11'h000, 8'h00, 7'h01, 1'b0);
    // Ten pushes then nine pops wrap the eight entries both ways
    for (i = 0; i < 10; i = i + 1)
      op(`PCS_CMD_CALL, i[10:0], 8'h00, 7'h01, 1'b0);
    for (i = 0; i < 9; i = i + 1)
      op(i % 3 == 0 ? `PCS_CMD_RETURN : (i % 3 == 1 ? `PCS_CMD_RET_LIT :
         `PCS_CMD_RET_INT), 11'h000, 8'h00, 7'h01, 1'b0);
    rc(`PCS_OFF_PC_HIGH_LATCH, 32'h0000_0008);
    // Jump issued through the command register instead of the decoder
    wr(`PCS_OFF_CORE_ARG, 32'h0000_0456);
    wr(`PCS_OFF_CORE_CMD, {28'h000_0000, `PCS_CMD_JUMP});
    pc = {lat[4:3], 11'h456};
    rc(`PCS_OFF_PC_FULL, 32'h0000_0C56);
    op(`PCS_CMD_INTERRUPT, 11'h000, 8'h00, 7'h01, 1'b0);
    op(`PCS_CMD_RET_INT, 11'h000, 8'h00, 7'h01, 1'b0);
    // Direct, indirect and self-referencing file accesses
    wr(`PCS_OFF_STATUS, 32'h0000_0020);
    op(`PCS_CMD_FILE_ACCESS, 11'h000, 8'h5A, 7'h25, 1'b1);
    cmp({22'h00_0000, rz, da}, {22'h00_0000, 1'b0, 9'h0A5});
    cmp({24'h00_0000, wdo}, 32'h0000_005A);
    wr(`PCS_OFF_STATUS, 32'h0000_0000);
    wr(`PCS_OFF_INDIRECT_POINTER, 32'h0000_00B7);
    op(`PCS_CMD_FILE_ACCESS, 11'h000, 8'h00, 7'h00, 1'b0);
    cmp({22'h00_0000, rz, da}, {22'h00_0000, 1'b0, 9'h0B7});
    wr(`PCS_OFF_INDIRECT_POINTER, 32'h0000_0080);
    op(`PCS_CMD_FILE_ACCESS, 11'h000, 8'h00, 7'h00, 1'b0);
    cmp({22'h00_0000, rz, da}, {22'h00_0000, 1'b1, 9'h080});
    op(`PCS_CMD_FILE_ACCESS, 11'h000, 8'h33, 7'h00, 1'b1);
    // Second reset in mid-run
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rc(`PCS_OFF_PC_FULL, 32'h0000_0000);
    results;
  end
  // Watchdog well beyond the few hundred cycles the tests take
  initial begin
    #20000;
    n_fail = n_fail + 1;
    results;
  end
endmodule // tb
`default_nettype wire
